// [src/cprc_defs.svh]
/*
  register offsets, field positions, reset values and timing counts of the
  clock, power and reset controller. assumes a 125 mhz hclk.
*/
`ifndef CPRC_DEFS_SVH
`define CPRC_DEFS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define CPRC_OFF_CLKSRC 12'h000
`define CPRC_OFF_PLLCFG 12'h004
`define CPRC_OFF_PLLCON 12'h008
`define CPRC_OFF_PLLSTAT 12'h00c
`define CPRC_OFF_CPUDIV 12'h010
`define CPRC_OFF_USBDIV 12'h014
`define CPRC_OFF_PCLKEN 12'h018
`define CPRC_OFF_PCLKDIV 12'h01c
`define CPRC_OFF_PWRMODE 12'h020
`define CPRC_OFF_OSCCTL 12'h024
`define CPRC_OFF_RSTSRC 12'h028
`define CPRC_OFF_BROWN 12'h02c
`define CPRC_OFF_BOOT 12'h030
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define CPRC_SRC_RC 2'h0
`define CPRC_SRC_MAIN 2'h1
`define CPRC_SRC_RTC 2'h2
`define CPRC_PLLCON_EN 0
`define CPRC_PLLCON_CONN 1
`define CPRC_PLLCFG_N_LSB 16
`define CPRC_BOOT_ADDR 32'h8100_0000
`define CPRC_BOOT_DATA_W 8'h10
`define CPRC_BOOT_ADDR_W 8'h18
`define CPRC_NPERIPH 8
// ----------------------------------------
// timing
// ----------------------------------------
`define CPRC_CLK_MHZ 125
`define CPRC_RC_MHZ 4
`define CPRC_RC_START_US 60
`define CPRC_SLEEP_RC_CYC 4
`define CPRC_SLEEP_MAIN_CYC 4096
`define CPRC_PD_RC_CYC 4
`define CPRC_PLL_LOCK_CYC 16'h0040
`endif

// [src/cprc_pkg.sv]
/*
  types of the clock, power and reset controller.
  assumes cprc_defs.svh is compiled alongside.
*/
package cprc_pkg;
  typedef enum logic [2:0] {
    CPRC_RUN = 3'b000,
    CPRC_IDLE = 3'b001,
    CPRC_SLEEP = 3'b011,
    CPRC_PDOWN = 3'b010,
    CPRC_WAKE = 3'b110
  } cprc_state_t;
  typedef struct packed {
    logic ext_n;
    logic watchdog;
    logic por;
    logic brown_rst;
  } cprc_rst_src_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [7:0] data_w;
    logic [7:0] addr_w;
  } cprc_boot_t;
endpackage

// [src/cprc_top.sv]
/*
  clock, power-mode and reset control with an ahb-lite register slave.
  assumes analog oscillators and the pll sit outside: this block only drives
  their enables, selects and pll n and m values and reads their ready and lock levels.
*/
// Our own choices: the AHB-Lite slave port and the register addresses.
// Operation
// - after any reset the internal rc oscillator is the selected source
// - software selects pll source among main, rc and rtc oscillators
// - pll pre-divider value n programmable from 1 to 256
// - pll multiplier m programmable from 1 to 32768, feeding the detector
// - pll off and bypassed at reset and in power-down; software enables it
// - cpu clock is pll source unless pll both enabled and connected
// - each peripheral has its own divider and clock gate; here only the gates are driven out, the pclkdiv word is stored and read back
// - idle halts cpu until reset or interrupt; peripherals keep running
// - sleep stops main oscillator and clocks, gates rc output, rtc runs
// - sleep entry turns pll off, disconnects it, zeroes cpu and usb dividers
// - sleep ends only on reset or a clockless wake interrupt
// - sleep wake waits 4 cycles on rc, 4096 on main oscillator
// - power-down does what sleep does and also powers rc off
// - power-down wake on rc waits 60 us start-up then 4 rc cycles
// - wake-up timer holds off main oscillator use until it is proven
// - pin, watchdog, power-on and brownout resets each reset the chip
// - reset holds until pin released, oscillator running, fixed clocks passed; here the oscillator is not checked
// - boot fetches from 0x8100_0000 with 16 data and 24 address lines
// - brownout below 2.95 v raises an interrupt line and a status flag
// - brownout below 2.65 v resets the chip when software enabled it
`timescale 1ns/1ps
`default_nettype none
`include "cprc_defs.svh"
module cprc_top #(
  parameter int unsigned WAKE_COUNT = 4096,
  parameter int unsigned RC_START_CYC = (`CPRC_RC_START_US * `CPRC_CLK_MHZ)
) (
  // ahb-lite slave
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // reset sources, pins
  input wire logic reset_pin_n,
  input wire logic watchdog_unit_rst,
  input wire logic por_n,
  input wire logic brownout_detector_low1,
  input wire logic brownout_detector_low2,
  // oscillators and pll status, wake and cpu interrupts
  input wire logic main_osc_ok,
  input wire logic pll_locked,
  input wire logic wake_irq,
  input wire logic cpu_irq,
  // outputs to clocking, reset, boot and brownout
  output logic [1:0] pll_source_sel,
  output logic main_osc_en,
  output logic internal_rc_osc_pwr,
  output logic internal_rc_osc_out_en,
  output logic rtc_osc_en,
  output logic pll_enable,
  output logic pll_connect,
  output logic [7:0] pll_n_minus1,
  output logic [14:0] pll_m_minus1,
  output logic [7:0] cpu_clock_div,
  output logic [7:0] usb_clock_div,
  output logic cpu_clock_run,
  output logic [`CPRC_NPERIPH-1:0] periph_clk_en,
  output logic chip_reset_n,
  output cprc_pkg::cprc_boot_t boot_cfg,
  output logic brownout_irq
);
  localparam int unsigned RC_DIV = `CPRC_CLK_MHZ / `CPRC_RC_MHZ;
  localparam logic [15:0] PD_WAIT = 16'(RC_START_CYC + `CPRC_PD_RC_CYC * RC_DIV);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [2:0] rp_s_reg, po_s_reg, wd_s_reg, b1_s_reg, b2_s_reg, mo_s_reg, lk_s_reg, wk_s_reg, ci_s_reg;
  logic rp_reg, po_reg, wd_reg, b1_reg, b2_reg, mo_reg, lk_reg, wk_reg, ci_reg;
  function automatic logic filt(input logic [2:0] s, input logic prev);
    filt = (s[1] == s[2]) ? s[2] : prev;
  endfunction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // active-low pins start released, so leaving reset reports no false pin event
      {rp_s_reg, po_s_reg} <= 6'h3f;
      {rp_reg, po_reg} <= 2'h3;
      {wd_s_reg, b1_s_reg, b2_s_reg} <= '0;
      {mo_s_reg, lk_s_reg, wk_s_reg, ci_s_reg} <= '0;
      {wd_reg, b1_reg, b2_reg, mo_reg, lk_reg, wk_reg, ci_reg} <= '0;
    end else begin
      rp_s_reg <= {rp_s_reg[1:0], reset_pin_n};
      wd_s_reg <= {wd_s_reg[1:0], watchdog_unit_rst};
      b1_s_reg <= {b1_s_reg[1:0], brownout_detector_low1};
      b2_s_reg <= {b2_s_reg[1:0], brownout_detector_low2};
      mo_s_reg <= {mo_s_reg[1:0], main_osc_ok};
      lk_s_reg <= {lk_s_reg[1:0], pll_locked};
      wk_s_reg <= {wk_s_reg[1:0], wake_irq};
      ci_s_reg <= {ci_s_reg[1:0], cpu_irq};
      po_s_reg <= {po_s_reg[1:0], por_n};
      rp_reg <= filt(rp_s_reg, rp_reg);
      wd_reg <= filt(wd_s_reg, wd_reg);
      b1_reg <= filt(b1_s_reg, b1_reg);
      b2_reg <= filt(b2_s_reg, b2_reg);
      mo_reg <= filt(mo_s_reg, mo_reg);
      lk_reg <= filt(lk_s_reg, lk_reg);
      wk_reg <= filt(wk_s_reg, wk_reg);
      ci_reg <= filt(ci_s_reg, ci_reg);
      po_reg <= filt(po_s_reg, po_reg);
    end
  end

  // ----------------------------------------
  // reset sequencing
  // ----------------------------------------
  logic brown_rst_en_reg;
  logic rst_req;
  logic [15:0] rst_cnt_reg;
  logic chip_rst_reg;
  cprc_pkg::cprc_rst_src_t rst_flags_reg;
  // por_n also feeds hresetn outside; the filtered copy catches a dip the reset tree misses
  assign rst_req = !rp_reg || !po_reg || wd_reg || (b2_reg && brown_rst_en_reg);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chip_rst_reg <= 1'b1;
      rst_cnt_reg <= '0;
    end else if (rst_req) begin
      chip_rst_reg <= 1'b1;
      rst_cnt_reg <= '0;
    end else if (chip_rst_reg) begin
      // counting only once no reset source is asserted; the oscillator is not checked
      if (rst_cnt_reg == 16'(WAKE_COUNT - 1)) begin
        chip_rst_reg <= 1'b0;
      end else begin
        rst_cnt_reg <= rst_cnt_reg + 16'h0001;
      end
    end
  end
  assign chip_reset_n = !chip_rst_reg;
  logic ahb_clr_flags;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_flags_reg <= '{ext_n: 1'b0, watchdog: 1'b0, por: 1'b1, brown_rst: 1'b0};
    end else begin
      // set beats software clear
      rst_flags_reg.ext_n <= !rp_reg || (rst_flags_reg.ext_n && !ahb_clr_flags);
      rst_flags_reg.watchdog <= wd_reg || (rst_flags_reg.watchdog && !ahb_clr_flags);
      rst_flags_reg.por <= !po_reg || (rst_flags_reg.por && !ahb_clr_flags);
      rst_flags_reg.brown_rst <= (b2_reg && brown_rst_en_reg) || (rst_flags_reg.brown_rst && !ahb_clr_flags);
    end
  end
  assign boot_cfg = '{addr: `CPRC_BOOT_ADDR, data_w: `CPRC_BOOT_DATA_W, addr_w: `CPRC_BOOT_ADDR_W};

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [1:0] src_reg;
  logic [7:0] n_reg;
  logic [14:0] m_reg;
  logic pll_en_reg, pll_conn_reg, main_en_reg, brown_irq_reg;
  logic [7:0] cpu_div_reg, usb_div_reg;
  logic [`CPRC_NPERIPH-1:0] pclk_en_reg;
  logic [31:0] pclk_div_reg;
  cprc_pkg::cprc_state_t state_reg;
  logic [15:0] wait_cnt_reg;
  logic [1:0] sleep_src_reg;
  logic mode_wr;
  logic [1:0] mode_req;
  logic wr_en;
  logic [11:0] wr_off;
  logic [31:0] wdat;
  logic entering_low;
  assign entering_low = mode_wr && (mode_req[1]);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_reg <= `CPRC_SRC_RC;
      n_reg <= '0;
      m_reg <= '0;
      pll_en_reg <= 1'b0;
      pll_conn_reg <= 1'b0;
      main_en_reg <= 1'b0;
      cpu_div_reg <= '0;
      usb_div_reg <= '0;
      pclk_en_reg <= '1;
      pclk_div_reg <= '0;
      brown_rst_en_reg <= 1'b0;
    end else if (chip_rst_reg) begin
      src_reg <= `CPRC_SRC_RC;
      pll_en_reg <= 1'b0;
      pll_conn_reg <= 1'b0;
      main_en_reg <= 1'b0;
    end else if (entering_low) begin
      pll_en_reg <= 1'b0;
      pll_conn_reg <= 1'b0;
      cpu_div_reg <= '0;
      usb_div_reg <= '0;
    end else if (wr_en) begin
      unique case (wr_off)
        `CPRC_OFF_CLKSRC: src_reg <= (wdat[1:0] == 2'h3) ? src_reg : wdat[1:0];
        `CPRC_OFF_PLLCFG: begin
          m_reg <= wdat[14:0];
          n_reg <= wdat[`CPRC_PLLCFG_N_LSB +: 8];
        end
        `CPRC_OFF_PLLCON: begin
          pll_en_reg <= wdat[`CPRC_PLLCON_EN];
          // connect only takes with lock and enable
          pll_conn_reg <= wdat[`CPRC_PLLCON_CONN] && wdat[`CPRC_PLLCON_EN] && lk_reg;
        end
        `CPRC_OFF_CPUDIV: cpu_div_reg <= wdat[7:0];
        `CPRC_OFF_USBDIV: usb_div_reg <= wdat[7:0];
        `CPRC_OFF_PCLKEN: pclk_en_reg <= wdat[`CPRC_NPERIPH-1:0];
        `CPRC_OFF_PCLKDIV: pclk_div_reg <= wdat;
        `CPRC_OFF_OSCCTL: main_en_reg <= wdat[0];
        `CPRC_OFF_BROWN: brown_rst_en_reg <= wdat[1];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // power mode machine
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= cprc_pkg::CPRC_RUN;
      wait_cnt_reg <= '0;
      sleep_src_reg <= `CPRC_SRC_RC;
    end else if (chip_rst_reg) begin
      state_reg <= cprc_pkg::CPRC_RUN;
    end else begin
      unique case (state_reg)
        cprc_pkg::CPRC_RUN: begin
          if (mode_wr) begin
            sleep_src_reg <= src_reg;
            unique case (mode_req)
              2'h1: state_reg <= cprc_pkg::CPRC_IDLE;
              2'h2: state_reg <= cprc_pkg::CPRC_SLEEP;
              2'h3: state_reg <= cprc_pkg::CPRC_PDOWN;
              default: ;
            endcase
          end
        end
        cprc_pkg::CPRC_IDLE: if (ci_reg || wk_reg) state_reg <= cprc_pkg::CPRC_RUN;
        cprc_pkg::CPRC_SLEEP: if (wk_reg) begin
          state_reg <= cprc_pkg::CPRC_WAKE;
          wait_cnt_reg <= (sleep_src_reg == `CPRC_SRC_MAIN) ? 16'(`CPRC_SLEEP_MAIN_CYC - 1)
                                                            : 16'(`CPRC_SLEEP_RC_CYC * RC_DIV - 1);
        end
        cprc_pkg::CPRC_PDOWN: if (wk_reg) begin
          state_reg <= cprc_pkg::CPRC_WAKE;
          wait_cnt_reg <= (sleep_src_reg == `CPRC_SRC_MAIN) ? 16'(WAKE_COUNT - 1)
                                                            : PD_WAIT - 16'h0001;
        end
        cprc_pkg::CPRC_WAKE: begin
          // main oscillator counting waits while its filtered ok level is low
          if (sleep_src_reg == `CPRC_SRC_MAIN && !mo_reg) begin
            wait_cnt_reg <= wait_cnt_reg;
          end else if (wait_cnt_reg == 16'h0000) begin
            state_reg <= cprc_pkg::CPRC_RUN;
          end else begin
            wait_cnt_reg <= wait_cnt_reg - 16'h0001;
          end
        end
        default: state_reg <= cprc_pkg::CPRC_RUN;
      endcase
    end
  end

  // ----------------------------------------
  // brownout interrupt line
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) brown_irq_reg <= 1'b0;
    else brown_irq_reg <= b1_reg;
  end
  assign brownout_irq = brown_irq_reg;

  // ----------------------------------------
  // main oscillator wake-up timer
  // ----------------------------------------
  // the filtered ok level can flicker during start-up, so a fixed count follows it
  logic [15:0] osc_cnt_reg;
  logic main_ready_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_cnt_reg <= '0;
      main_ready_reg <= 1'b0;
    end else if (!main_osc_en || !mo_reg) begin
      osc_cnt_reg <= '0;
      main_ready_reg <= 1'b0;
    end else if (osc_cnt_reg == 16'(WAKE_COUNT - 1)) begin
      main_ready_reg <= 1'b1;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 16'h0001;
    end
  end

  // ----------------------------------------
  // clock outputs
  // ----------------------------------------
  logic low_pwr;
  assign low_pwr = (state_reg == cprc_pkg::CPRC_SLEEP) || (state_reg == cprc_pkg::CPRC_PDOWN);
  assign pll_source_sel = src_reg;
  // main oscillator unusable until proven after start
  assign main_osc_en = main_en_reg && !low_pwr && !chip_rst_reg;
  assign internal_rc_osc_pwr = state_reg != cprc_pkg::CPRC_PDOWN;
  assign internal_rc_osc_out_en = !low_pwr;
  assign rtc_osc_en = 1'b1;
  assign pll_enable = pll_en_reg;
  assign pll_connect = pll_en_reg && pll_conn_reg;
  assign pll_n_minus1 = n_reg;
  assign pll_m_minus1 = m_reg;
  assign cpu_clock_div = cpu_div_reg;
  assign usb_clock_div = usb_div_reg;
  assign cpu_clock_run = (state_reg == cprc_pkg::CPRC_RUN) && !chip_rst_reg
                         && (src_reg != `CPRC_SRC_MAIN || main_ready_reg);
  assign periph_clk_en = (low_pwr || state_reg == cprc_pkg::CPRC_WAKE) ? '0 : pclk_en_reg;

  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  logic ph_wr_reg, ph_rd_reg;
  logic [11:0] ph_off_reg;
  logic [31:0] rdata_reg;
  logic acc;
  assign acc = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_reg <= 1'b0;
      ph_rd_reg <= 1'b0;
      ph_off_reg <= '0;
    end else begin
      ph_wr_reg <= acc && hwrite;
      ph_rd_reg <= acc && !hwrite;
      ph_off_reg <= haddr[11:0];
    end
  end
  assign wr_en = ph_wr_reg;
  assign wr_off = ph_off_reg;
  assign wdat = hwdata;
  assign mode_wr = ph_wr_reg && ph_off_reg == `CPRC_OFF_PWRMODE && wdat[1:0] != 2'h0
                   && state_reg == cprc_pkg::CPRC_RUN && !chip_rst_reg;
  assign mode_req = wdat[1:0];
  assign ahb_clr_flags = ph_wr_reg && ph_off_reg == `CPRC_OFF_RSTSRC;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg <= '0;
    end else if (acc && !hwrite) begin
      unique case (haddr[11:0])
        `CPRC_OFF_CLKSRC: rdata_reg <= {30'h0, src_reg};
        `CPRC_OFF_PLLCFG: rdata_reg <= {8'h0, n_reg, 1'b0, m_reg};
        `CPRC_OFF_PLLCON: rdata_reg <= {30'h0, pll_conn_reg, pll_en_reg};
        `CPRC_OFF_PLLSTAT: rdata_reg <= {29'h0, lk_reg, pll_conn_reg, pll_en_reg};
        `CPRC_OFF_CPUDIV: rdata_reg <= {24'h0, cpu_div_reg};
        `CPRC_OFF_USBDIV: rdata_reg <= {24'h0, usb_div_reg};
        `CPRC_OFF_PCLKEN: rdata_reg <= {24'h0, pclk_en_reg};
        `CPRC_OFF_PCLKDIV: rdata_reg <= pclk_div_reg;
        `CPRC_OFF_PWRMODE: rdata_reg <= {29'h0, state_reg};
        `CPRC_OFF_OSCCTL: rdata_reg <= {30'h0, mo_reg, main_en_reg};
        `CPRC_OFF_RSTSRC: rdata_reg <= {28'h0, rst_flags_reg};
        `CPRC_OFF_BROWN: rdata_reg <= {30'h0, brown_rst_en_reg, b1_reg};
        `CPRC_OFF_BOOT: rdata_reg <= `CPRC_BOOT_ADDR;
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end
  assign hrdata = rdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule
`default_nettype wire

// [sim/cprc_props.sv]
/*
  port assertions for cprc_top.
  assumes one hclk domain and register offsets from address zero.
*/
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module cprc_props #(
  parameter int unsigned WAKE_COUNT = 4096
) (
  // bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // sources
  input wire logic watchdog_unit_rst,
  input wire logic brownout_detector_low1,
  input wire logic pll_locked,
  // controls
  input wire logic [1:0] pll_source_sel,
  input wire logic main_osc_en,
  input wire logic internal_rc_osc_pwr,
  input wire logic internal_rc_osc_out_en,
  input wire logic rtc_osc_en,
  input wire logic pll_enable,
  input wire logic pll_connect,
  input wire logic [7:0] cpu_clock_div,
  input wire logic [7:0] usb_clock_div,
  input wire logic cpu_clock_run,
  input wire logic chip_reset_n,
  input wire cprc_pkg::cprc_boot_t boot_cfg,
  input wire logic brownout_irq
);
  logic wr_pm;
  wire logic sleep_wr = wr_pm && (hwdata == 32'h2 || hwdata == 32'h3);
  wire logic pd_wr = wr_pm && hwdata == 32'h3;
  wire logic idle_wr = wr_pm && hwdata == 32'h1;
  // data phase of a mode write; hwdata is only valid one cycle after the address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pm <= 1'b0;
    end else if (hready) begin
      wr_pm <= hsel && htrans[1] && hwrite && haddr[11:0] == 12'h020;
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  boot_const_a:
    assert property (boot_cfg == {32'h8100_0000, 8'h10, 8'h18}) else $error("boot setup wrong");
  rc_default_a:
    assert property (!$past(hresetn) |-> pll_source_sel == 2'h0 && !pll_enable && !pll_connect)
      else $error("not on rc after reset");
  sleep_clear_a:
    assert property (sleep_wr |=> cpu_clock_div == 8'h00 && usb_clock_div == 8'h00 && !pll_enable && !pll_connect)
      else $error("sleep entry left pll or dividers");
  sleep_clocks_a:
    assert property (sleep_wr |-> ##[1:4] (!internal_rc_osc_out_en && rtc_osc_en && !main_osc_en && !cpu_clock_run))
      else $error("clocks still running in sleep");
  pdown_rc_a:
    assert property (pd_wr |-> ##[1:4] !internal_rc_osc_pwr) else $error("rc powered in power-down");
  conn_gate_a:
    assert property ($rose(pll_connect) |-> pll_enable && pll_locked) else $error("pll connected unlocked");
  idle_halt_a:
    assert property (idle_wr |-> ##[1:4] !cpu_clock_run) else $error("cpu runs in idle");
  wd_reset_a:
    assert property (watchdog_unit_rst |-> ##[1:6] !chip_reset_n) else $error("watchdog reset missed");
  reset_hold_a:
    assert property ($rose(chip_reset_n) |-> $past(chip_reset_n, WAKE_COUNT) == 1'b0)
      else $error("reset released early");
  brown_irq_a:
    assert property (brownout_detector_low1 |-> ##[1:5] brownout_irq) else $error("brownout line missed");
  cover property (sleep_wr);
  cover property ($rose(pll_connect));
  cover property ($fell(chip_reset_n));
endmodule
bind cprc_top cprc_props #(.WAKE_COUNT(WAKE_COUNT)) u_props (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .watchdog_unit_rst, .brownout_detector_low1, .pll_locked, .pll_source_sel,
  .main_osc_en, .internal_rc_osc_pwr, .internal_rc_osc_out_en, .rtc_osc_en, .pll_enable, .pll_connect,
  .cpu_clock_div, .usb_clock_div, .cpu_clock_run, .chip_reset_n, .boot_cfg, .brownout_irq);
`default_nettype wire

// [sim/cprc_top_tb.sv]
/*
  self-checking bench for cprc_top through its ahb-lite slave.
  assumes short wake and rc start-up counts set by parameter.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
// ----------------------------------------
// bench
// ----------------------------------------
module cprc_top_tb;
  localparam int unsigned WAKE_N = 8;
  localparam int unsigned RC_N = 10;
  localparam int LO[3] = '{124, 4096, RC_N + 124};
  localparam int HI[3] = '{136, 4140, RC_N + 136};
  localparam logic [3:0] RST_BIT[3] = '{4'h4, 4'h8, 4'h1};
  logic hclk, hresetn, hsel, hwrite, reset_pin_n, watchdog_unit_rst;
  logic brownout_detector_low1, brownout_detector_low2, main_osc_ok, pll_locked, wake_irq, cpu_irq;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire logic hready, por_n, hreadyout, hresp, main_osc_en, internal_rc_osc_pwr, internal_rc_osc_out_en;
  wire logic rtc_osc_en, pll_enable, pll_connect, cpu_clock_run, chip_reset_n, brownout_irq;
  wire logic [31:0] hrdata;
  wire logic [1:0] pll_source_sel;
  wire logic [7:0] pll_n_minus1, cpu_clock_div, usb_clock_div, periph_clk_en;
  wire logic [14:0] pll_m_minus1;
  wire cprc_pkg::cprc_boot_t boot_cfg;
  int errors, tests_run, cyc_cnt, n;
  assign hready = hreadyout;
  assign por_n = hresetn;
  cprc_top #(.WAKE_COUNT(WAKE_N), .RC_START_CYC(RC_N)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .reset_pin_n, .watchdog_unit_rst, .por_n,
    .brownout_detector_low1, .brownout_detector_low2, .main_osc_ok, .pll_locked, .wake_irq, .cpu_irq,
    .pll_source_sel, .main_osc_en, .internal_rc_osc_pwr, .internal_rc_osc_out_en, .rtc_osc_en, .pll_enable,
    .pll_connect, .pll_n_minus1, .pll_m_minus1, .cpu_clock_div, .usb_clock_div, .cpu_clock_run,
    .periph_clk_en, .chip_reset_n, .boot_cfg, .brownout_irq);
  always #4 hclk = ~hclk;
  // crude oscillator: proven a cycle after enable, lost a cycle after it is stopped
  always @(posedge hclk) main_osc_ok <= main_osc_en;
  always @(posedge hclk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    @(posedge hclk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  // bounded wait; the count doubles as the measured latency
  task automatic wait_for(input logic sel, output int k);
    k = 0;
    while (k < 6000 && (sel ? chip_reset_n : cpu_clock_run) !== 1'b1) begin
      @(posedge hclk);
      k++;
    end
  endtask
  task automatic src_drive(input int k, input logic v);
    case (k)
      0: watchdog_unit_rst <= v;
      1: reset_pin_n <= ~v;
      default: brownout_detector_low2 <= v;
    endcase
  endtask
  initial begin
    {hclk, hresetn, hsel, hwrite, watchdog_unit_rst, brownout_detector_low1, brownout_detector_low2} = '0;
    {pll_locked, wake_irq, cpu_irq, haddr, hwdata, htrans} = '0;
    reset_pin_n = 1'b1;
    hsize = 3'h2;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    wait_for(1'b1, n);
    `CHK(n >= WAKE_N && n <= WAKE_N + 8, 1'b1)
    `CHK(pll_source_sel, 2'h0)
    `CHK({pll_enable, pll_connect}, 2'h0)
    `CHK(boot_cfg, {32'h8100_0000, 8'h10, 8'h18})
    `CHK({hreadyout, hresp}, 2'b10)
    rdc(12'h030, 32'h8100_0000);
    rdc(12'h018, 32'h0000_00ff);
    rdc(12'h008, 32'h0);
    rdc(12'h040, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(12'h000, i);
      `CHK(pll_source_sel, 2'(i))
    end
    for (int i = 0; i < 2; i++) begin
      wr(12'h004, i ? 32'h00ff_7fff : 32'h0);
      `CHK({pll_n_minus1, pll_m_minus1}, i ? 23'h7f_ffff : 23'h0)
    end
    rdc(12'h004, 32'h00ff_7fff);
    wr(12'h004, 32'h0000_0063); // m of 100 and n of 1 on the rtc source left selected above
    `CHK({pll_n_minus1, pll_m_minus1}, 23'h00_0063)
    wr(12'h008, 32'h3);
    `CHK({pll_enable, pll_connect}, 2'b10)
    pll_locked <= 1'b1;
    repeat (5) @(posedge hclk);
    wr(12'h008, 32'h3);
    rdc(12'h00c, 32'h7);
    wr(12'h010, 32'h5);
    wr(12'h014, 32'h7);
    wr(12'h018, 32'h5a);
    `CHK({cpu_clock_div, usb_clock_div, periph_clk_en}, 24'h05_075a)
    wr(12'h01c, 32'h1234_5678);
    rdc(12'h01c, 32'h1234_5678);
    wr(12'h020, 32'h1);
    `CHK({cpu_clock_run, periph_clk_en}, 9'h05a)
    rdc(12'h020, 32'h1);
    cpu_irq <= 1'b1;
    wait_for(1'b0, n);
    `CHK(n < 10, 1'b1)
    cpu_irq <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      wr(12'h024, 32'(i == 1));
      repeat (10) @(posedge hclk);
      wr(12'h000, 32'(i == 1));
      wr(12'h008, 32'h1);
      wr(12'h020, i == 2 ? 32'h3 : 32'h2);
      repeat (3) @(posedge hclk);
      `CHK({cpu_clock_div, usb_clock_div, pll_enable, pll_connect}, 18'h0)
      `CHK({internal_rc_osc_out_en, rtc_osc_en, main_osc_en, cpu_clock_run}, 4'b0100)
      `CHK(internal_rc_osc_pwr, i != 2)
      cpu_irq <= 1'b1;
      repeat (20) @(posedge hclk);
      `CHK(cpu_clock_run, 1'b0)
      cpu_irq <= 1'b0;
      wake_irq <= 1'b1;
      wait_for(1'b0, n);
      wake_irq <= 1'b0;
      `CHK(n >= LO[i] && n <= HI[i], 1'b1)
    end
    wr(12'h02c, 32'h0);
    brownout_detector_low2 <= 1'b1;
    repeat (10) @(posedge hclk);
    `CHK(chip_reset_n, 1'b1)
    brownout_detector_low2 <= 1'b0;
    // let the filtered level fall before arming, else arming itself resets the chip
    repeat (6) @(posedge hclk);
    wr(12'h02c, 32'h2);
    for (int k = 0; k < 3; k++) begin
      wr(12'h028, 32'h0);
      src_drive(k, 1'b1);
      repeat (8) @(posedge hclk);
      `CHK(chip_reset_n, 1'b0)
      src_drive(k, 1'b0);
      wait_for(1'b1, n);
      `CHK(n >= WAKE_N && n <= WAKE_N + 8, 1'b1)
      bus(1'b0, 12'h028, 32'h0);
      `CHK(rd[3:0], RST_BIT[k])
    end
    brownout_detector_low1 <= 1'b1;
    repeat (6) @(posedge hclk);
    bus(1'b0, 12'h02c, 32'h0);
    `CHK({brownout_irq, rd[0]}, 2'b11)
    brownout_detector_low1 <= 1'b0;
    repeat (6) @(posedge hclk);
    `CHK(brownout_irq, 1'b0)
    wrap_up();
  end
endmodule
`default_nettype wire
